// File: src/io_port_consts.svh
// Offsets, field positions, reset values and timing for the six-pin I/O port.
// Assumes inclusion by bare name from the design module.
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_PORT_LEVELS   8'h00
`define OFS_PORT_MODIFY   8'h04
`define OFS_PORT_DIR      8'h08
`define OFS_ANALOG_SEL    8'h0c
`define OFS_PULL_UP_EN    8'h10
`define OFS_CHANGE_EN     8'h14
`define OFS_IRQ_CONTROL   8'h18
`define OFS_OPTION        8'h1c

// Reset values
`define RST_PORT_DIR      6'h3f
`define RST_ANALOG_SEL    8'hff
`define RST_PULL_UP_EN    6'h37
`define RST_CHANGE_EN     6'h00

// Field positions
`define BIT_GLOBAL_IRQ    7
`define BIT_CHANGE_IRQ_EN 3
`define BIT_CHANGE_FLAG   0
`define BIT_PULL_UP_CTRL  7
`define BIT_INPUT_ONLY    3
`define MOD_MASK_LSB      0
`define MOD_VALUE_LSB     8

// Synchroniser depth for pins and straps
`define SYNC_DEPTH        2

`endif

// File: src/io_port_pkg.sv
// Types shared by the six-pin I/O port and its surroundings.
// Assumes the constants header sits beside it.
package io_port_pkg;

  // AXI4-Lite response codes used by the slave
  typedef enum logic [1:0] {
    resp_okay   = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_t;

  // Per-pin drive bundle towards the pad ring
  typedef struct packed {
    logic [5:0] level;    // Output latch value
    logic [5:0] enable;   // Driver enable, high while driving
    logic [5:0] pull_up;  // Weak pull-up on
  } pin_drive_t;

endpackage : io_port_pkg

// File: src/six_bit_io_port.sv
// Six-pin bidirectional I/O port with pull-ups and change detection.
// Assumes an AXI4-Lite master on clk, pads that resolve out/enable, and
// static configuration straps from outside the clock domain.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "io_port_consts.svh"

module six_bit_io_port #(
  parameter int ADDR_W = 8                // AXI address width
) (
  input  wire logic                       clk,              // 10 MHz clock
  input  wire logic                       rst,              // Power-on reset
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,     // Write address
  input  wire logic                       s_axi_awvalid,    // Write address valid
  output logic                            s_axi_awready,    // Write address ready
  input  wire logic [31:0]                s_axi_wdata,      // Write data
  input  wire logic [3:0]                 s_axi_wstrb,      // Write strobes
  input  wire logic                       s_axi_wvalid,     // Write data valid
  output logic                            s_axi_wready,     // Write data ready
  output logic [1:0]                      s_axi_bresp,      // Write response
  output logic                            s_axi_bvalid,     // Write response valid
  input  wire logic                       s_axi_bready,     // Write response ready
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,     // Read address
  input  wire logic                       s_axi_arvalid,    // Read address valid
  output logic                            s_axi_arready,    // Read address ready
  output logic [31:0]                     s_axi_rdata,      // Read data
  output logic [1:0]                      s_axi_rresp,      // Read response
  output logic                            s_axi_rvalid,     // Read data valid
  input  wire logic                       s_axi_rready,     // Read data ready
  input  wire logic [5:0]                 pin_in,           // Pad input levels
  output io_port_pkg::pin_drive_t         pin_drive,        // Pad drive bundle
  input  wire logic                       master_clear_enable, // Config strap
  input  wire logic                       crystal_mode,     // Oscillator strap
  input  wire logic                       brownout_reset,   // Brown-out request
  output logic                            warm_reset,       // Master clear or brown-out
  output logic                            change_irq,       // Recognised interrupt
  output logic                            wake_request      // Wake from sleep
);

  // Refuse address buses too narrow for the decode, which looks at a full byte
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // Two-stage synchronisers for pins and straps
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic       mce;
  logic       xtal;
  logic       bor;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta   <= 6'h00;
      pin_sync   <= 6'h00;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      pin_meta   <= pin_in;
      pin_sync   <= pin_meta;
      strap_meta <= {brownout_reset, crystal_mode, master_clear_enable};
      strap_sync <= strap_meta;
    end
  end

  assign mce  = strap_sync[0];
  assign xtal = strap_sync[1];
  assign bor  = strap_sync[2];

  // Control registers
  logic [5:0] out_latch;
  logic [5:0] dir;
  logic [7:0] analog_sel;
  logic [5:0] pull_en;
  logic [5:0] change_en;
  logic       global_irq_enable;
  logic       change_ie;
  logic       change_flag;
  logic       pull_ctrl;          // One disables all pull-ups except the input-only pin's
  logic [5:0] last_read;
  logic       warm;

  // Master clear needs the low pin level while the strap enables it
  assign warm = bor | (mce & ~pin_sync[`BIT_INPUT_ONLY]);

  // Bus handshake state
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic              do_read;
  logic              wr_port;
  logic              wr_modify;
  logic              rd_port;

  assign do_write  = aw_full & w_full & ~s_axi_bvalid;
  assign do_read   = s_axi_arvalid & s_axi_arready;
  assign wr_port   = do_write & w_strb[0] & (aw_addr[7:0] == `OFS_PORT_LEVELS);
  assign wr_modify = do_write & (aw_addr[7:0] == `OFS_PORT_MODIFY);
  assign rd_port   = do_read & (s_axi_araddr[7:0] == `OFS_PORT_LEVELS);

  // Effective direction and digital read value per pin
  logic [5:0] dir_eff;
  logic [5:0] analog_pin;
  logic [5:0] port_value;
  logic [5:0] mismatch;
  logic [5:0] next_pull;

  assign dir_eff[2:0] = dir[2:0];
  assign dir_eff[3]   = 1'b1;
  assign dir_eff[5:4] = xtal ? 2'b11 : dir[5:4];
  // Analog channels sit on pins 0, 1, 2 and 4 only
  assign analog_pin = {1'b0, analog_sel[3], 1'b0, analog_sel[2:0]};

  for (genvar i = 0; i < 6; i++) begin : g_pin
    if (i == `BIT_INPUT_ONLY) begin : g_input_only
      assign port_value[i] = mce ? 1'b0 : pin_sync[i];
      assign next_pull[i]  = mce;
    end else begin : g_io
      assign port_value[i] = analog_pin[i] ? 1'b0 : pin_sync[i];
      // Pull-up also dropped for analog pins, whose digital input is off
      assign next_pull[i]  = pull_en[i] & ~pull_ctrl & dir_eff[i]
                             & ~analog_pin[i];
    end
    assign mismatch[i] = change_en[i] & (port_value[i] != last_read[i]);
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_full       <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!aw_full) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_full       <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!w_full) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  logic wr_mapped;
  assign wr_mapped = (aw_addr[ADDR_W-1:5] == '0) && (aw_addr[1:0] == 2'b00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= io_port_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? io_port_pkg::resp_okay : io_port_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; warm reset restores every register here but the output latch
  logic wr_low;
  assign wr_low = do_write & w_strb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_latch  <= 6'h00;
      dir        <= `RST_PORT_DIR;
      analog_sel <= `RST_ANALOG_SEL;
      pull_en    <= `RST_PULL_UP_EN;
      change_en  <= `RST_CHANGE_EN;
      global_irq_enable        <= 1'b0;
      change_ie  <= 1'b0;
      pull_ctrl  <= 1'b1;
    end else if (warm) begin
      dir        <= `RST_PORT_DIR;
      analog_sel <= `RST_ANALOG_SEL;
      pull_en    <= `RST_PULL_UP_EN;
      change_en  <= `RST_CHANGE_EN;
      global_irq_enable        <= 1'b0;
      change_ie  <= 1'b0;
      pull_ctrl  <= 1'b1;
    end else begin
      if (wr_port) begin
        out_latch <= w_data[5:0];
      end else if (wr_modify) begin
        // Unmasked bits take the pin levels, as a byte-wide store would
        out_latch <= (port_value & ~w_data[`MOD_MASK_LSB +: 6])
                   | (w_data[`MOD_VALUE_LSB +: 6] & w_data[`MOD_MASK_LSB +: 6]);
      end
      if (wr_low) begin
        case (aw_addr[7:0])
          `OFS_PORT_DIR:    dir        <= w_data[5:0];
          `OFS_ANALOG_SEL:  analog_sel <= w_data[7:0];
          `OFS_PULL_UP_EN:  pull_en    <= w_data[5:0] & `RST_PULL_UP_EN;
          `OFS_CHANGE_EN:   change_en  <= w_data[5:0];
          `OFS_IRQ_CONTROL: begin
            global_irq_enable       <= w_data[`BIT_GLOBAL_IRQ];
            change_ie <= w_data[`BIT_CHANGE_IRQ_EN];
          end
          `OFS_OPTION:      pull_ctrl  <= w_data[`BIT_PULL_UP_CTRL];
          default:          ;
        endcase
      end
    end
  end

  // Last-read latch: a port-level read, a low-strobe port write or a modify write ends the mismatch; no warm reset here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_read <= 6'h00;
    end else if (rd_port || wr_port || wr_modify) begin
      last_read <= port_value;
    end
  end

  // Change flag: a mismatch wins over a software clear
  logic flag_wr;
  logic capture;
  assign flag_wr = wr_low & (aw_addr[7:0] == `OFS_IRQ_CONTROL);
  // The capture cycle compares against a latch being replaced, so skip it
  assign capture = rd_port | wr_port | wr_modify;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      change_flag <= 1'b0;
    end else if ((|mismatch) && !capture) begin
      change_flag <= 1'b1;
    end else if (flag_wr) begin
      change_flag <= w_data[`BIT_CHANGE_FLAG];
    end
  end

  // Read data path
  logic [7:0] read_value;
  logic       rd_mapped;
  always_comb begin
    rd_mapped = (s_axi_araddr[1:0] == 2'b00);
    case (s_axi_araddr[7:0])
      `OFS_PORT_LEVELS: read_value = {2'b00, port_value};
      `OFS_PORT_MODIFY: read_value = {2'b00, out_latch};
      `OFS_PORT_DIR:    read_value = {2'b00, dir_eff};
      `OFS_ANALOG_SEL:  read_value = analog_sel;
      `OFS_PULL_UP_EN:  read_value = {2'b00, xtal ? 2'b11 : pull_en[5:4],
                                      1'b0, pull_en[2:0]};
      `OFS_CHANGE_EN:   read_value = {2'b00, xtal ? 2'b11 : change_en[5:4],
                                      change_en[3:0]};
      `OFS_IRQ_CONTROL: read_value = {global_irq_enable, 3'b000, change_ie, 2'b00, change_flag};
      `OFS_OPTION:      read_value = {pull_ctrl, 7'h00};
      default: begin
        read_value = 8'h00;
        rd_mapped  = 1'b0;
      end
    endcase
    if (s_axi_araddr[ADDR_W-1:5] != '0) begin
      rd_mapped = 1'b0;
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= io_port_pkg::resp_okay;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_mapped ? read_value : 8'h00};
      s_axi_rresp   <= rd_mapped ? io_port_pkg::resp_okay : io_port_pkg::resp_slverr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Registered pad drive and event outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_drive    <= '0;
      change_irq   <= 1'b0;
      wake_request <= 1'b0;
      warm_reset   <= 1'b0;
    end else begin
      pin_drive.level   <= out_latch;
      pin_drive.enable  <= ~dir_eff;
      pin_drive.pull_up <= next_pull;
      change_irq        <= change_flag & change_ie & global_irq_enable;
      wake_request      <= change_flag & change_ie;
      warm_reset        <= warm;
    end
  end

  // Checks on the behaviour above
  input_only_hiz_a: assert property (@(posedge clk) disable iff (rst)
    !pin_drive.enable[3]) else $error("input-only pin driven");
  pull_off_out_a: assert property (@(posedge clk) disable iff (rst)
    (pin_drive.pull_up & pin_drive.enable) == 6'h00)
    else $error("pull-up on while driving");
  flag_sets_a: assert property (@(posedge clk) disable iff (rst)
    (|mismatch) && !capture |=> change_flag) else $error("flag not set");
  set_beats_clear_a: assert property (@(posedge clk) disable iff (rst)
    flag_wr && !w_data[0] && (|mismatch) && !capture |=> change_flag)
    else $error("clear beat mismatch");
  analog_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd_port |=> (s_axi_rdata[5:0] & $past(analog_pin)) == 6'h00)
    else $error("analog pin read nonzero");
  upper_bits_zero_a: assert property (@(posedge clk) disable iff (rst)
    do_read && (s_axi_araddr[7:0] == `OFS_PORT_DIR) |=> s_axi_rdata[7:6] == 2'b00
    && s_axi_rdata[3]) else $error("direction readback wrong");
  latch_drives_a: assert property (@(posedge clk) disable iff (rst || warm)
    wr_port |-> ##2 pin_drive.level == $past(w_data[5:0], 2))
    else $error("latch not driven");
  irq_needs_gie_a: assert property (@(posedge clk) disable iff (rst)
    change_irq |-> $past(global_irq_enable)) else $error("irq without global enable");
  master_clear_pin_read_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd_port && mce |=> !s_axi_rdata[3]) else $error("input-only read wrong");
  wake_follows_a: assert property (@(posedge clk) disable iff (rst)
    change_flag && change_ie |=> wake_request) else $error("no wake");

  flag_set_c: cover property (@(posedge clk) disable iff (rst) $rose(change_flag));
  irq_c:      cover property (@(posedge clk) disable iff (rst) $rose(change_irq));
  modify_c:   cover property (@(posedge clk) disable iff (rst) wr_modify);

endmodule : six_bit_io_port
`default_nettype wire

// File: dv/pad_model.sv
// Pad ring model for the six-pin port: resolves each pin level.
// Assumes the bench never drives a pin that the device is driving.
`timescale 1ns/1ps
`default_nettype none

module pad_model (
  input  wire logic                     clk,     // System clock
  input  wire io_port_pkg::pin_drive_t  drive,   // Device drive bundle
  input  wire logic [5:0]               ext_en,  // Bench drives the pin
  input  wire logic [5:0]               ext_val, // Bench drive level
  output logic [5:0]                    pin      // Resolved pad level
);
  logic [5:0] float_pat = 6'h15;

  // A pin nobody drives or pulls keeps changing, so a stale level is never trusted
  always @(posedge clk) float_pat <= ~float_pat;

  // Device driver first, then the bench, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (drive.enable[i]) pin[i] = drive.level[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (drive.pull_up[i]) pin[i] = 1'b1;
      else pin[i] = float_pat[i];
    end
  end
endmodule : pad_model

`default_nettype wire

// File: dv/six_bit_io_port_test.sv
// Self-checking bench for the six-pin port: register bus, pads, straps.
// Assumes pad_model and the design sources are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module six_bit_io_port_test;
  logic        clk, rst, mce, xtal, bor;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, brsp;
  logic [5:0]  pin, ext_en, ext_val;
  logic        warm, irq, wake;
  io_port_pkg::pin_drive_t drv;
  int          n_mismatch, total_checks;

  six_bit_io_port six_bit_io_port_i (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin), .pin_drive(drv), .master_clear_enable(mce), .crystal_mode(xtal),
    .brownout_reset(bor), .warm_reset(warm), .change_irq(irq), .wake_request(wake));

  pad_model pad_model_i (.clk(clk), .drive(drv), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // One write; address and data offered together, each released once taken.
  // Waits as long as the slave takes; only the watchdog ends a hang.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    brsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // One read; an extra edge at the end keeps rready from being reassigned
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rdat = rdata;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rdchk

  task automatic test_reset;
    rdchk(8'h08, 32'h3f);
    rdchk(8'h0c, 32'hff);
    rdchk(8'h14, 32'h00);
    rdchk(8'h1c, 32'h80);
    chk(drv.pull_up, 6'h00);
    rd(8'h42);
    chk(rresp, 2'b10);
    wr(8'h40, 32'h0);
    chk(brsp, 2'b10);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_output;
    wr(8'h1c, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h25);
    // A port write without its low strobe must leave the latch alone
    wstrb <= 4'h0;
    wr(8'h00, 32'h3f);
    wstrb <= 4'hf;
    idle(3);
    chk(drv.enable, 6'h37);
    chk(drv.level, 6'h25);
    chk(drv.pull_up, 6'h00);
    rdchk(8'h08, 32'h08);
    rdchk(8'h00, 32'h25);
    $display("test_output done");
  endtask : test_output

  // Analog pin reads zero yet still drives, so a modify picks up the zero
  task automatic test_analog_rmw;
    wr(8'h0c, 32'h01);
    rdchk(8'h00, 32'h24);
    chk(drv.level, 6'h25);
    chk(drv.enable, 6'h37);
    wr(8'h04, 32'h0202);
    rdchk(8'h04, 32'h26);
    idle(3);
    chk(drv.level, 6'h26);
    // Raise pin four first so that its analog select really hides a one
    wr(8'h04, 32'h1010);
    wr(8'h0c, 32'h08);
    rdchk(8'h00, 32'h26);
    wr(8'h0c, 32'h0);
    $display("test_analog_rmw done");
  endtask : test_analog_rmw

  task automatic test_pullup;
    wr(8'h08, 32'h3f);
    idle(3);
    chk(drv.pull_up, 6'h37);
    rdchk(8'h00, 32'h37);
    wr(8'h08, 32'h3e);
    idle(3);
    chk(drv.pull_up, 6'h36);
    wr(8'h1c, 32'h80);
    idle(3);
    chk(drv.pull_up, 6'h00);
    wr(8'h1c, 32'h0);
    $display("test_pullup done");
  endtask : test_pullup

  // Input-only pin held high first so master clear does not fire
  task automatic test_master_clear_pin;
    ext_val <= 6'h08;
    idle(3);
    mce <= 1'b1;
    idle(5);
    chk(warm, 1'b0);
    chk(drv.pull_up, 6'h3e);
    rdchk(8'h00, 32'h36);
    mce <= 1'b0;
    idle(5);
    chk(drv.pull_up, 6'h36);
    rdchk(8'h00, 32'h3e);
    $display("test_master_clear_pin done");
  endtask : test_master_clear_pin

  task automatic test_change;
    rd(8'h00);
    wr(8'h14, 32'h02);
    wr(8'h18, 32'h88);
    idle(3);
    chk(irq, 1'b0);
    ext_en  <= 6'h0a;
    ext_val <= 6'h08;
    idle(5);
    chk(wake, 1'b1);
    chk(irq, 1'b1);
    rdchk(8'h18, 32'h89);
    wr(8'h18, 32'h88);
    rdchk(8'h18, 32'h89);
    rd(8'h00);
    wr(8'h18, 32'h88);
    rdchk(8'h18, 32'h88);
    chk(irq, 1'b0);
    wr(8'h18, 32'h08);
    ext_val <= 6'h0a;
    idle(5);
    chk(irq, 1'b0);
    chk(wake, 1'b1);
    $display("test_change done");
  endtask : test_change

  // Last-read latch holds pin one high across a brown-out: a cleared latch
  // would raise a false mismatch, a kept one only a real change
  task automatic test_warm;
    rd(8'h00);
    wr(8'h18, 32'h0);
    rdchk(8'h18, 32'h00);
    bor <= 1'b1;
    idle(5);
    chk(warm, 1'b1);
    bor <= 1'b0;
    idle(5);
    wr(8'h0c, 32'h0);
    wr(8'h14, 32'h02);
    idle(3);
    rdchk(8'h18, 32'h00);
    ext_val <= 6'h08;
    idle(5);
    wr(8'h18, 32'h0);
    rdchk(8'h18, 32'h01);
    $display("test_warm done");
  endtask : test_warm

  task automatic test_crystal;
    ext_en <= 6'h08;
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0f);
    xtal <= 1'b1;
    idle(5);
    chk(drv.enable, 6'h07);
    rdchk(8'h08, 32'h38);
    rdchk(8'h10, 32'h37);
    xtal <= 1'b0;
    idle(5);
    rdchk(8'h08, 32'h08);
    rdchk(8'h10, 32'h07);
    $display("test_crystal done");
  endtask : test_crystal

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Watchdog: the tests need well under two thousand cycles
  initial begin
    #(100 * 20000);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    {mce, xtal, bor} = 3'h0;
    ext_en = 6'h08;
    ext_val = 6'h00;
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_output();
    test_analog_rmw();
    test_pullup();
    test_master_clear_pin();
    test_change();
    test_warm();
    test_crystal();
    summarize();
  end
endmodule : six_bit_io_port_test

`default_nettype wire
